// File: cdw_card_model.sv
// card model: answers command frames, takes a write block, returns crc status and busy
`timescale 1ns/10ps
module cdw_card_model #(
  parameter int BLOCK_BITS = 64,
  parameter int BUSY_CLKS = 20
) (
  input wire logic card_clk,
  input wire logic cmd_wire,
  input wire logic dat_wire,
  input wire logic respond,
  output logic cmd_drv,
  output logic cmd_val,
  output logic dat_drv,
  output logic dat_val
);
  localparam logic [4:0] CRC_OK = 5'h05; // start, status 010, end
  // command: take a frame, then answer unless told to stay silent
  initial
  begin
    cmd_drv = 1'b0;
    cmd_val = 1'b1;
    forever
    begin
      @(posedge card_clk);
      if (!cmd_wire && !cmd_drv)
      begin
        repeat (cdw_pkg::CMD_BITS - 1) @(posedge card_clk);
        repeat (2) @(negedge card_clk);
        for (int i = 0; i < cdw_pkg::CMD_BITS && respond; i++)
        begin
          cmd_drv <= 1'b1;
          cmd_val <= (i >= 2) && (i[0] || i == cdw_pkg::CMD_BITS - 1);
          @(negedge card_clk);
        end
        cmd_drv <= 1'b0;
      end
    end
  end
  // data: take block and end bit, send crc status, hold busy low
  initial
  begin
    dat_drv = 1'b0;
    dat_val = 1'b1;
    forever
    begin
      @(posedge card_clk);
      if (!dat_wire && !dat_drv)
      begin
        repeat (BLOCK_BITS + 1) @(posedge card_clk);
        repeat (2) @(negedge card_clk);
        for (int i = 4; i >= 0; i--)
        begin
          dat_drv <= 1'b1;
          dat_val <= CRC_OK[i];
          @(negedge card_clk);
        end
        dat_val <= 1'b0;
        repeat (BUSY_CLKS) @(negedge card_clk);
        dat_drv <= 1'b0;
      end
    end
  end
endmodule

// File: cdw_fifo.sv
// transmit fifo: flip-flop storage, synchronous clear, byte-wide push and pop
`timescale 1ns/10ps
module cdw_fifo #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  output logic [7:0] pop_data,
  output logic [AW:0] level,
  output logic empty,
  output logic full
);
  logic [7:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  // pointers; clear empties within one clock
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || clr)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (do_push) wp_q <= wp_q + 1'b1;
      if (do_pop) rp_q <= rp_q + 1'b1;
    end
  end

  // storage write
  always_ff @(posedge clk_sys)
  begin
    if (do_push) mem_q[wp_q[AW-1:0]] <= push_data;
  end

  assign pop_data = mem_q[rp_q[AW-1:0]];
  assign level = wp_q - rp_q;
  assign empty = (level == '0);
  assign full = (level == DEPTH[AW:0]);
endmodule

// File: cdw_pkg.sv
// package: register map, fields and timing for the card dma write sequencer
package cdw_pkg;
  // register word offsets (byte addresses)
  localparam logic [5:0] OFS_CTRL = 6'h00; // operation_control_reg
  localparam logic [5:0] OFS_DMA = 6'h04; // dma_control_reg
  localparam logic [5:0] OFS_BLKCNT = 6'h08; // block_count_reg
  localparam logic [5:0] OFS_CMDSTART = 6'h0C; // command_start_reg
  localparam logic [5:0] OFS_STATUS = 6'h10; // card_status_reg
  localparam logic [5:0] OFS_IFLAG = 6'h14; // event flags, write 1 clears
  localparam logic [5:0] OFS_IEN = 6'h18; // event enables
  localparam logic [5:0] OFS_FIFO = 6'h1C; // fifo data port
  localparam logic [5:0] OFS_CMD = 6'h20; // command word
  // operation_control_reg bits
  localparam int CTRL_DATA_TX_EN = 0;
  localparam int CTRL_SEQ_OFF = 1;
  localparam int CTRL_FIFO_CLR = 2;
  // dma_control_reg fields
  localparam int DMA_SET_LSB = 0; // 3-bit ready threshold select
  localparam int DMA_AUTO = 6;
  localparam int DMA_EN = 7;
  localparam logic [7:0] DMA_RESET = 8'h00;
  // card_status_reg bits
  localparam int ST_BUSY = 0;
  localparam int ST_DATA_BUSY = 1;
  localparam int ST_FIFO_EMPTY = 2;
  localparam int ST_FIFO_FULL = 3;
  localparam int ST_DMA_REQ = 4;
  // event flag bits
  localparam int EV_FIFO_EMPTY = 0;
  localparam int EV_FIFO_READY = 1;
  localparam int EV_DATA_RESP = 2;
  localparam int EV_BUSY_END = 3;
  localparam int EV_CRC_ERR = 4;
  localparam int EV_DATA_TMO = 5;
  localparam int EV_CMD_TMO = 6;
  localparam int EV_MBLK_DONE = 7;
  localparam int EV_CMD_DONE = 8;
  localparam int EV_NUM = 9;
  // timing
  localparam int STREAM_TAIL_CARD_CLKS = 24;
  localparam int CMD_BITS = 48;
  localparam int RESP_TMO_CARD_CLKS = 64;
  localparam int DATA_TMO_CARD_CLKS = 1024;
  localparam int CRC_STATUS_BITS = 5; // start, 3 status bits, end
endpackage

// File: cdw_seq.sv
// card dma write sequencer: avalon registers, fifo fill, command and write data to card
`timescale 1ns/10ps
// Operation
// - ready flag past threshold; software sets enable
// - stream keeps sending after empty; wait 24
// - auto mode handles inter-block pauses in hardware
// - no command response raises timeout flag
// - auto end shown by busy, done flag
// - data errors flagged; software stops sequence
// - data busy bit after response; busy end flag
// - disabled event source never sets flag
module cdw_seq #(
  parameter int FIFO_DEPTH = 16,
  parameter int FIFO_AW = 4,
  parameter int BLOCK_BYTES = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic dma_req,
  input wire logic card_clk_in,
  output logic card_cmd_o,
  output logic card_cmd_oe_n,
  input wire logic card_cmd_i,
  output logic card_dat_o,
  output logic card_dat_oe_n,
  input wire logic card_dat_i
);
  localparam int EV_W = cdw_pkg::EV_NUM;
  typedef enum logic [3:0] {
    CDW_IDLE = 4'h0, CDW_CMD = 4'h1, CDW_RESP = 4'h2, CDW_WAIT = 4'h3,
    CDW_DSTART = 4'h4, CDW_DBITS = 4'h5, CDW_DSTOP = 4'h6, CDW_CRCST = 4'h7,
    CDW_BUSY = 4'h8, CDW_TAIL = 4'h9
  } cdw_state_t;

  cdw_state_t st_q;
  logic [7:0] dma_q;
  logic [15:0] blk_q;
  logic stream_q;
  logic [47:0] cmd_q;
  logic [EV_W-1:0] ien_q;
  logic [EV_W-1:0] flag_q;
  logic [2:0] ck_q;
  logic [2:0] cmdi_q;
  logic [2:0] dati_q;
  logic [10:0] cnt_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic [15:0] bytes_q;
  logic [31:0] rdata_q;
  logic ack_q;

  // sampled card clock and lines; change counts once stages 2 and 3 agree
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ck_q <= '0;
      cmdi_q <= 3'h7;
      dati_q <= 3'h7;
    end
    else
    begin
      ck_q <= {ck_q[1:0], card_clk_in};
      cmdi_q <= {cmdi_q[1:0], card_cmd_i};
      dati_q <= {dati_q[1:0], card_dat_i};
    end
  end
  logic ck_lvl_q;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) ck_lvl_q <= 1'b0;
    else if (ck_q[1] == ck_q[2]) ck_lvl_q <= ck_q[2];
  end
  wire ck_agree = (ck_q[1] == ck_q[2]);
  wire ck_fall = ck_agree && ck_lvl_q && !ck_q[2]; // drive outputs on falling edge
  wire ck_rise = ck_agree && !ck_lvl_q && ck_q[2]; // sample inputs on rising edge
  wire cmd_in = cmdi_q[2];
  wire dat_in = dati_q[2];

  // bus decode
  // writes land at the edge where waitrequest is low
  wire wr = avs_write && ack_q;
  wire sel_ctrl = wr && avs_address == cdw_pkg::OFS_CTRL && avs_byteenable[0];
  wire sel_dma = wr && avs_address == cdw_pkg::OFS_DMA && avs_byteenable[0];
  wire sel_blk = wr && avs_address == cdw_pkg::OFS_BLKCNT;
  wire sel_start = wr && avs_address == cdw_pkg::OFS_CMDSTART && avs_byteenable[0] && avs_writedata[0];
  wire sel_flag = wr && avs_address == cdw_pkg::OFS_IFLAG;
  wire sel_ien = wr && avs_address == cdw_pkg::OFS_IEN;
  wire sel_cmd = wr && avs_address == cdw_pkg::OFS_CMD;
  // fifo accepts writes that enable lane 0 but not all four lanes; a full word write is dropped
  wire sel_fifo = wr && avs_address == cdw_pkg::OFS_FIFO && avs_byteenable[0] && !(&avs_byteenable);
  wire seq_off = sel_ctrl && avs_writedata[cdw_pkg::CTRL_SEQ_OFF];
  wire fifo_clr = sel_ctrl && avs_writedata[cdw_pkg::CTRL_FIFO_CLR];
  wire tx_go = sel_ctrl && avs_writedata[cdw_pkg::CTRL_DATA_TX_EN];
  wire auto_on = dma_q[cdw_pkg::DMA_AUTO];

  // fifo, one byte per bus write
  logic [7:0] f_dout;
  logic [FIFO_AW:0] f_lvl;
  logic f_empty;
  logic f_full;
  logic f_pop;
  cdw_fifo #(.DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk_sys(clk_sys), .rst_n(rst_n), .clr(fifo_clr), .push(sel_fifo),
    .push_data(avs_writedata[7:0]), .pop(f_pop), .pop_data(f_dout),
    .level(f_lvl), .empty(f_empty), .full(f_full)
  );

  // ready threshold from set field: 2^set bytes, capped at depth
  function automatic logic [FIFO_AW:0] thresh(input logic [2:0] s);
    logic [7:0] t;
    t = 8'h01 << s;
    thresh = (t > FIFO_DEPTH[7:0]) ? FIFO_DEPTH[FIFO_AW:0] : t[FIFO_AW:0];
  endfunction
  wire fifo_ready = f_lvl > thresh(dma_q[2:0]);
  assign dma_req = dma_q[cdw_pkg::DMA_EN] && !f_full && !fifo_clr;

  // register writes
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      dma_q <= cdw_pkg::DMA_RESET;
      blk_q <= '0;
      ien_q <= '0;
      cmd_q <= '0;
      stream_q <= 1'b0;
    end
    else
    begin
      if (sel_dma) dma_q <= avs_writedata[7:0];
      if (sel_blk) blk_q <= avs_writedata[15:0];
      if (sel_ien) ien_q <= avs_writedata[EV_W-1:0];
      if (sel_cmd) cmd_q <= {avs_writedata[29:0], 18'h3FFFF};
      if (sel_start) stream_q <= avs_writedata[1];
      else if (st_q == CDW_WAIT && tx_go && auto_on && blk_q != '0) blk_q <= blk_q - 1'b1;
    end
  end

  // events raised by the sequencer
  logic [EV_W-1:0] ev;
  wire [EV_W-1:0] ev_en = ev & ien_q;
  wire [EV_W-1:0] ev_clr = sel_flag ? avs_writedata[EV_W-1:0] : '0;
  // sticky flags, set wins over a write-one clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) flag_q <= '0;
    else flag_q <= (flag_q & ~ev_clr) | ev_en;
  end

  // sequencer
  wire bit_done = (bit_q == 3'h7);
  assign f_pop = ck_fall && st_q == CDW_DBITS && bit_done;
  always_comb
  begin
    ev = '0;
    ev[cdw_pkg::EV_FIFO_EMPTY] = f_empty && st_q == CDW_DBITS;
    ev[cdw_pkg::EV_FIFO_READY] = fifo_ready;
    ev[cdw_pkg::EV_CMD_TMO] = st_q == CDW_RESP && ck_rise && cnt_q == 11'(cdw_pkg::RESP_TMO_CARD_CLKS);
    ev[cdw_pkg::EV_CMD_DONE] = st_q == CDW_CMD && ck_fall && cnt_q == 11'(cdw_pkg::CMD_BITS);
    ev[cdw_pkg::EV_DATA_TMO] = st_q == CDW_BUSY && ck_rise && cnt_q == 11'(cdw_pkg::DATA_TMO_CARD_CLKS);
    ev[cdw_pkg::EV_CRC_ERR] = st_q == CDW_CRCST && ck_rise && cnt_q == 11'h4 && sh_q[2:0] != 3'b010;
    ev[cdw_pkg::EV_DATA_RESP] = st_q == CDW_CRCST && ck_rise && cnt_q == 11'h4 && sh_q[2:0] == 3'b010;
    ev[cdw_pkg::EV_BUSY_END] = st_q == CDW_BUSY && ck_rise && dat_in;
    ev[cdw_pkg::EV_MBLK_DONE] = st_q == CDW_BUSY && ck_rise && dat_in && auto_on && blk_q == '0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || seq_off)
    begin
      st_q <= CDW_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      bit_q <= '0;
      bytes_q <= '0;
      card_cmd_o <= 1'b1;
      card_dat_o <= 1'b1;
      card_cmd_oe_n <= 1'b1;
      card_dat_oe_n <= 1'b1;
    end
    else
    begin
      case (st_q)
        CDW_IDLE:
        begin
          cnt_q <= '0;
          if (sel_start) st_q <= CDW_CMD;
        end
        CDW_CMD: if (ck_fall)
        begin
          card_cmd_oe_n <= (cnt_q == 11'(cdw_pkg::CMD_BITS));
          card_cmd_o <= (cnt_q == 11'(cdw_pkg::CMD_BITS)) ? 1'b1 : cmd_q[6'(47 - cnt_q)]; // idle high after frame
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == 11'(cdw_pkg::CMD_BITS))
          begin
            cnt_q <= '0;
            st_q <= CDW_RESP;
          end
        end
        CDW_RESP: if (ck_rise)
        begin
          cnt_q <= cnt_q + 1'b1;
          if (!cmd_in) st_q <= CDW_WAIT; // response start bit seen
          else if (cnt_q == 11'(cdw_pkg::RESP_TMO_CARD_CLKS)) st_q <= CDW_IDLE;
        end
        // data only after enable; auto mode restarts each block itself
        CDW_WAIT: if (tx_go || (auto_on && fifo_ready && flag_q[cdw_pkg::EV_DATA_RESP] == 1'b0 && bytes_q != '0))
        begin
          bytes_q <= '0;
          st_q <= CDW_DSTART;
        end
        CDW_DSTART: if (ck_fall)
        begin
          card_dat_oe_n <= 1'b0;
          card_dat_o <= 1'b0;
          bit_q <= '0;
          st_q <= CDW_DBITS;
        end
        CDW_DBITS: if (ck_fall)
        begin
          card_dat_o <= stream_q && f_empty ? 1'b1 : f_dout[3'(7 - bit_q)];
          bit_q <= bit_q + 1'b1;
          if (bit_done)
          begin
            bytes_q <= bytes_q + 1'b1;
            if (!stream_q && bytes_q == 16'(BLOCK_BYTES - 1)) st_q <= CDW_DSTOP;
            else if (stream_q && f_empty)
            begin
              cnt_q <= '0;
              st_q <= CDW_TAIL;
            end
          end
        end
        CDW_DSTOP: if (ck_fall)
        begin
          card_dat_o <= 1'b1;
          card_dat_oe_n <= 1'b1;
          cnt_q <= '0;
          st_q <= CDW_CRCST;
        end
        CDW_CRCST: if (ck_rise)
        begin
          sh_q <= {sh_q[6:0], dat_in};
          if (cnt_q != '0 || !dat_in) cnt_q <= cnt_q + 1'b1;
          if (cnt_q == 11'h4)
          begin
            cnt_q <= '0;
            st_q <= CDW_BUSY;
          end
        end
        CDW_BUSY: if (ck_rise)
        begin
          cnt_q <= cnt_q + 1'b1;
          if (dat_in) st_q <= (auto_on && blk_q != '0) ? CDW_WAIT : CDW_IDLE;
          else if (cnt_q == 11'(cdw_pkg::DATA_TMO_CARD_CLKS)) st_q <= CDW_IDLE;
        end
        CDW_TAIL: if (ck_fall)
        begin
          card_dat_o <= 1'b1;
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == 11'(cdw_pkg::STREAM_TAIL_CARD_CLKS)) card_dat_oe_n <= 1'b1;
        end
        default: st_q <= CDW_IDLE;
      endcase
    end
  end

  // status word
  wire [31:0] status_w = {27'h0, dma_req, f_full, f_empty,
    st_q == CDW_BUSY && !dat_in, st_q != CDW_IDLE};
  wire [31:0] rd_mux =
    avs_address == cdw_pkg::OFS_CTRL ? 32'h0 :
    avs_address == cdw_pkg::OFS_DMA ? {24'h0, dma_q} :
    avs_address == cdw_pkg::OFS_BLKCNT ? {16'h0, blk_q} :
    avs_address == cdw_pkg::OFS_STATUS ? status_w :
    avs_address == cdw_pkg::OFS_IFLAG ? {{(32-EV_W){1'b0}}, flag_q} :
    avs_address == cdw_pkg::OFS_IEN ? {{(32-EV_W){1'b0}}, ien_q} :
    avs_address == cdw_pkg::OFS_FIFO ? {{(31-FIFO_AW){1'b0}}, f_lvl} : 32'h0;

  // one wait cycle per access, then answer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      if (avs_read && !ack_q) rdata_q <= rd_mux;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;
endmodule

// File: cdw_seq_properties.sv
// checker: bus handshake, reset state and card line framing of the sequencer
`timescale 1ns/10ps
module cdw_seq_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic dma_req,
  input wire logic card_clk_in,
  input wire logic card_cmd_o,
  input wire logic card_cmd_oe_n,
  input wire logic card_dat_o
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // bus answer timing
  a_wait_first_cycle: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait on first request cycle");
  a_answer_next_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer late");
  a_idle_no_wait: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait while idle");
  a_readdata_holds: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  // state right after reset
  a_reset_quiet: assert property ($rose(rst_n) |-> card_cmd_oe_n && !dma_req && avs_readdata == 32'h0)
    else $error("outputs not quiet after reset");
  // card line framing
  a_cmd_frame_hold: assert property ($fell(card_cmd_oe_n) |-> !card_cmd_o ##1 !card_cmd_oe_n [*8])
    else $error("command frame start wrong");
  a_cmd_drive_low_clk: assert property ($changed(card_cmd_o) |-> !card_clk_in)
    else $error("command bit moved on high card clock");
  a_dat_drive_low_clk: assert property ($changed(card_dat_o) |-> !card_clk_in)
    else $error("data bit moved on high card clock");
endmodule
bind cdw_seq cdw_seq_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .dma_req(dma_req), .card_clk_in(card_clk_in), .card_cmd_o(card_cmd_o),
  .card_cmd_oe_n(card_cmd_oe_n), .card_dat_o(card_dat_o));

// File: test_cdw_seq.sv
// testbench: register rows, fifo fill and clear, command timeout and a block write
`timescale 1ns/10ps
module test_cdw_seq;
  typedef struct {logic wr; logic [5:0] a; logic [31:0] d; logic [31:0] e;} cdw_row_t;
  logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, dma_req, card_clk_in, respond;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic card_cmd_o, card_cmd_oe_n, card_dat_o, card_dat_oe_n, cmd_drv, cmd_val, dat_drv, dat_val;
  logic cmd_q[$];
  logic dat_q[$];
  logic [63:0] blk, got;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  // wire levels with pull-ups when nobody drives
  wire cmd_w = !card_cmd_oe_n ? card_cmd_o : (cmd_drv ? cmd_val : 1'b1);
  wire dat_w = !card_dat_oe_n ? card_dat_o : (dat_drv ? dat_val : 1'b1);
  cdw_row_t rows [8] = '{
    '{1'b0, cdw_pkg::OFS_IFLAG, 32'h0, 32'h0},
    '{1'b1, cdw_pkg::OFS_IEN, 32'h000001FF, 32'h0},
    '{1'b0, cdw_pkg::OFS_IEN, 32'h0, 32'h000001FF},
    '{1'b1, cdw_pkg::OFS_DMA, 32'h00000043, 32'h0},
    '{1'b0, cdw_pkg::OFS_DMA, 32'h0, 32'h00000043},
    '{1'b0, cdw_pkg::OFS_STATUS, 32'h0, 32'h00000004},
    '{1'b1, 6'h3C, 32'hFFFFFFFF, 32'h0},
    '{1'b0, cdw_pkg::OFS_STATUS, 32'h0, 32'h00000004}};
  cdw_seq #(.FIFO_DEPTH(16), .FIFO_AW(4), .BLOCK_BYTES(8)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dma_req(dma_req), .card_clk_in(card_clk_in), .card_cmd_o(card_cmd_o), .card_cmd_oe_n(card_cmd_oe_n),
    .card_cmd_i(cmd_w), .card_dat_o(card_dat_o), .card_dat_oe_n(card_dat_oe_n), .card_dat_i(dat_w));
  cdw_card_model #(.BLOCK_BITS(64), .BUSY_CLKS(20)) card (.card_clk(card_clk_in), .cmd_wire(cmd_w),
    .dat_wire(dat_w), .respond(respond), .cmd_drv(cmd_drv), .cmd_val(cmd_val), .dat_drv(dat_drv),
    .dat_val(dat_val));
  // clocks: system 4 ns, card 64 ns with unrelated phase
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial
  begin
    card_clk_in = 1'b0;
    #33;
    forever #32 card_clk_in = ~card_clk_in;
  end
  // bits seen on the card lines while the block drives them
  always @(posedge card_clk_in)
  begin
    if (!card_cmd_oe_n)
      cmd_q.push_back(card_cmd_o);
    if (!card_dat_oe_n)
      dat_q.push_back(card_dat_o);
  end
  // hang guard
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !w;
    avs_write <= w;
    do
      @(posedge clk_sys);
    while (avs_waitrequest);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdm(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(rd & m, e);
  endtask
  task automatic wait_flag(input int b);
    rd = 32'h0;
    for (int n = 0; n < 3000 && rd[b] !== 1'b1; n++)
      bus(1'b0, cdw_pkg::OFS_IFLAG, 32'h0, 4'hF);
    chk(32'(rd[b]), 32'h1);
  endtask
  task automatic push(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++)
      bus(1'b1, cdw_pkg::OFS_FIFO, {24'h0, 8'(b + i)}, 4'h1);
  endtask
  initial
  begin
    rst_n = 1'b0;
    respond = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i])
    begin
      bus(rows[i].wr, rows[i].a, rows[i].d, 4'hF);
      if (!rows[i].wr)
        chk(rd, rows[i].e);
    end
    // fifo threshold, refused lanes, full and clear
    bus(1'b1, cdw_pkg::OFS_DMA, 32'h00000081, 4'hF);
    rdm(cdw_pkg::OFS_STATUS, 32'h1C, 32'h14);
    push(2, 8'hC0);
    rdm(cdw_pkg::OFS_IFLAG, 32'h2, 32'h0);
    push(1, 8'hC2);
    rdm(cdw_pkg::OFS_IFLAG, 32'h2, 32'h2);
    bus(1'b1, cdw_pkg::OFS_FIFO, 32'h000000AA, 4'hF);
    bus(1'b1, cdw_pkg::OFS_FIFO, 32'h0000AA00, 4'h2);
    rdm(cdw_pkg::OFS_FIFO, 32'h1F, 32'h3);
    push(13, 8'h10);
    rdm(cdw_pkg::OFS_STATUS, 32'h1C, 32'h08);
    bus(1'b1, cdw_pkg::OFS_CTRL, 32'h4, 4'hF);
    rdm(cdw_pkg::OFS_STATUS, 32'h1C, 32'h14);
    rdm(cdw_pkg::OFS_FIFO, 32'h1F, 32'h0);
    bus(1'b1, cdw_pkg::OFS_IFLAG, 32'h1FF, 4'hF);
    // disabled source stays clear
    bus(1'b1, cdw_pkg::OFS_IEN, 32'h0, 4'hF);
    push(3, 8'h20);
    rdm(cdw_pkg::OFS_IFLAG, 32'h2, 32'h0);
    bus(1'b1, cdw_pkg::OFS_CTRL, 32'h6, 4'hF);
    bus(1'b1, cdw_pkg::OFS_IEN, 32'h1FF, 4'hF);
    bus(1'b1, cdw_pkg::OFS_DMA, 32'h0, 4'hF);
    // silent card: command timeout
    cmd_q.delete();
    bus(1'b1, cdw_pkg::OFS_CMD, 32'h01234567, 4'hF);
    bus(1'b1, cdw_pkg::OFS_CMDSTART, 32'h1, 4'hF);
    wait_flag(cdw_pkg::EV_CMD_TMO);
    chk(32'(cmd_q.size()), 32'(cdw_pkg::CMD_BITS));
    bus(1'b1, cdw_pkg::OFS_CTRL, 32'h2, 4'hF);
    bus(1'b1, cdw_pkg::OFS_DMA, 32'h0, 4'hF);
    bus(1'b1, cdw_pkg::OFS_IFLAG, 32'h1FF, 4'hF);
    // single block write with crc status and busy
    respond <= 1'b1;
    cmd_q.delete();
    dat_q.delete();
    bus(1'b1, cdw_pkg::OFS_CTRL, 32'h4, 4'hF);
    bus(1'b1, cdw_pkg::OFS_BLKCNT, 32'h0, 4'hF);
    bus(1'b1, cdw_pkg::OFS_CMD, 32'h02345678, 4'hF);
    bus(1'b1, cdw_pkg::OFS_CMDSTART, 32'h1, 4'hF);
    wait_flag(cdw_pkg::EV_CMD_DONE);
    push(8, 8'h5A);
    for (int i = 0; i < 8; i++)
      blk = {blk[55:0], 8'(8'h5A + i)};
    chk(32'(dat_q.size()), 32'h0);
    bus(1'b1, cdw_pkg::OFS_CTRL, 32'h1, 4'hF);
    wait_flag(cdw_pkg::EV_DATA_RESP);
    // let the busy level pass the card line synchroniser
    repeat (16) @(posedge clk_sys);
    rdm(cdw_pkg::OFS_STATUS, 32'h2, 32'h2);
    for (int k = 0; k < 64; k++)
      got = {got[62:0], dat_q[k + 1]};
    chk(32'(dat_q[0]), 32'h0);
    chk(got[63:32], blk[63:32]);
    chk(got[31:0], blk[31:0]);
    wait_flag(cdw_pkg::EV_BUSY_END);
    rdm(cdw_pkg::OFS_STATUS, 32'h2, 32'h0);
    bus(1'b1, cdw_pkg::OFS_CTRL, 32'h2, 4'hF);
    rdm(cdw_pkg::OFS_STATUS, 32'h1, 32'h0);
    report_and_stop();
  end
endmodule
